//--- gcc_top.sv
// receiver companion control: pins, i2c link, idle gating, aiding store
`timescale 1ns/1ns
module gcc_top #(
	parameter int RTC_PERIOD_CYC = gcc_pkg::RTC_PERIOD_CYC,
	parameter int RTC_PULSE_CYC  = gcc_pkg::RTC_PULSE_CYC,
	parameter logic [6:0] RX_ADDR = gcc_pkg::RX_ADDR_DEFAULT
) (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       srst,
	// host settings, taken on settings_load
	input  wire logic       settings_load,
	input  wire logic       rx_mode,
	input  wire logic [7:0] receiver_io_setting,
	input  wire logic [2:0] fn_supply,
	input  wire logic [2:0] fn_ready,
	input  wire logic [2:0] fn_rtc,
	input  wire logic       power_saving_en,
	input  wire logic       local_aiding_en,
	input  wire logic       extended_support,
	// host byte relay to the receiver
	input  wire logic       host_req,
	input  wire logic       host_rw,
	input  wire logic [7:0] host_wdata,
	output logic            host_ready,
	output logic            host_done,
	output logic            host_ack_ok,
	output logic [7:0]      host_rdata,
	// power management
	output logic            idle_allowed,
	output logic            wake_pulse,
	output logic            aid_store_valid,
	// receiver i2c link
	input  wire logic       scl_i,
	output logic            scl_o,
	output logic            scl_oe,
	input  wire logic       sda_i,
	output logic            sda_o,
	output logic            sda_oe,
	// receiver gpio pins
	output logic            gps_supply_enable_pin_o,
	output logic            gps_supply_enable_pin_oe,
	input  wire logic       gps_data_ready_pin_i,
	output logic            gps_data_ready_pin_pd_en,
	output logic            gps_rtc_sync_pin_o,
	output logic            gps_rtc_sync_pin_oe
);

	////////////////////////////////
	// settings

	logic       mode_reg;
	logic [7:0] iocfg_reg;
	logic [2:0] fn_supply_reg;
	logic [2:0] fn_ready_reg;
	logic [2:0] fn_rtc_reg;
	logic       psv_reg;
	logic       aid_en_reg;
	logic       ext_reg;
	logic       mode_d_reg;

	always_ff @(posedge clk) begin
		if (srst) begin
			mode_reg      <= 1'b0;
			iocfg_reg     <= gcc_pkg::IOCFG_RESET;
			fn_supply_reg <= gcc_pkg::PINFN_SUPPLY_EN;
			fn_ready_reg  <= gcc_pkg::PINFN_DATA_READY;
			fn_rtc_reg    <= gcc_pkg::PINFN_RTC_SYNC;
			psv_reg       <= 1'b0;
			aid_en_reg    <= 1'b0;
			ext_reg       <= 1'b0;
		end else if (settings_load) begin
			mode_reg      <= rx_mode;
			iocfg_reg     <= receiver_io_setting;
			fn_supply_reg <= fn_supply;
			fn_ready_reg  <= fn_ready;
			fn_rtc_reg    <= fn_rtc;
			psv_reg       <= power_saving_en;
			aid_en_reg    <= local_aiding_en;
			ext_reg       <= extended_support;
		end
	end

	always_ff @(posedge clk) begin
		if (srst)
			mode_d_reg <= 1'b0;
		else
			mode_d_reg <= mode_reg;
	end

	wire power_up = mode_reg && !mode_d_reg;

	////////////////////////////////
	// input synchronisers

	logic [1:0] scl_sync_reg;
	logic [1:0] sda_sync_reg;
	logic [1:0] dr_sync_reg;
	logic       dr_d_reg;

	always_ff @(posedge clk) begin
		if (srst) begin
			scl_sync_reg <= 2'h3;
			sda_sync_reg <= 2'h3;
			dr_sync_reg  <= 2'h0;
			dr_d_reg     <= 1'b0;
		end else begin
			scl_sync_reg <= {scl_sync_reg[0], scl_i};
			sda_sync_reg <= {sda_sync_reg[0], sda_i};
			dr_sync_reg  <= {dr_sync_reg[0], gps_data_ready_pin_i};
			dr_d_reg     <= dr_sync_reg[1];
		end
	end

	////////////////////////////////
	// rtc sync pulse train, restarted at every receiver power-up

	logic [31:0] rtc_cnt_reg;
	wire rtc_wrap  = (rtc_cnt_reg == 32'(RTC_PERIOD_CYC - 1));
	wire rtc_level = mode_reg && (rtc_cnt_reg < 32'(RTC_PULSE_CYC));

	always_ff @(posedge clk) begin
		if (srst || !mode_reg || rtc_wrap)
			rtc_cnt_reg <= 32'h0000_0000;
		else
			rtc_cnt_reg <= rtc_cnt_reg + 32'h0000_0001;
	end

	////////////////////////////////
	// pin drive, registered so a setting change cannot glitch a pin

	wire supply_level;
	wire supply_drive;
	wire ready_sense;
	wire rtc_out_level;

	gcc_pin_mux u_pin_mux (
		.rx_mode       (mode_reg),
		.extended      (ext_reg),
		.io_setting    (iocfg_reg),
		.fn_supply     (fn_supply_reg),
		.fn_ready      (fn_ready_reg),
		.fn_rtc        (fn_rtc_reg),
		.rtc_level     (rtc_level),
		.supply_level  (supply_level),
		.supply_drive  (supply_drive),
		.ready_sense   (ready_sense),
		.rtc_out_level (rtc_out_level)
	);

	logic sup_o_reg;
	logic sup_oe_reg;
	logic pd_en_reg;
	logic sense_reg;
	logic rtc_o_reg;
	logic rtc_oe_reg;

	always_ff @(posedge clk) begin
		if (srst) begin
			// undriven in reset: the board pull-down keeps it off
			sup_o_reg  <= 1'b0;
			sup_oe_reg <= 1'b0;
			pd_en_reg  <= 1'b1;
			sense_reg  <= 1'b0;
			rtc_o_reg  <= 1'b0;
			rtc_oe_reg <= 1'b0;
		end else begin
			sup_o_reg  <= supply_level;
			sup_oe_reg <= supply_drive;
			pd_en_reg  <= !ready_sense;
			sense_reg  <= ready_sense;
			rtc_o_reg  <= rtc_out_level;
			rtc_oe_reg <= 1'b1;
		end
	end

	assign gps_supply_enable_pin_o  = sup_o_reg;
	assign gps_supply_enable_pin_oe = sup_oe_reg;
	assign gps_data_ready_pin_pd_en = pd_en_reg;
	assign gps_rtc_sync_pin_o       = rtc_o_reg;
	assign gps_rtc_sync_pin_oe      = rtc_oe_reg;

	////////////////////////////////
	// i2c engine

	gcc_i2c_if i2c_bus ();

	gcc_i2c_master u_i2c (
		.clk    (clk),
		.srst   (srst),
		.bus    (i2c_bus),
		.scl_in (scl_sync_reg[1]),
		.sda_in (sda_sync_reg[1]),
		.scl_oe (scl_oe),
		.sda_oe (sda_oe)
	);

	assign scl_o = 1'b0;
	assign sda_o = 1'b0;

	////////////////////////////////
	// aiding store and request sequencer

	gcc_pkg::gcc_aid_state_t aid_state_reg;
	logic [7:0] aid_mem_reg [gcc_pkg::AID_BYTES];
	logic [2:0] aid_idx_reg;
	logic       aid_valid_reg;
	logic       req_reg;
	logic       rw_reg;
	logic [7:0] wdata_reg;
	logic       host_done_reg;
	logic       host_ack_reg;
	logic [7:0] host_rdata_reg;

	wire seq_idle = (aid_state_reg == gcc_pkg::GCC_A_IDLE);
	wire link_up  = mode_reg;
	wire eng_free = !i2c_bus.busy && !req_reg;
	wire aid_go   = power_up && aid_en_reg;
	wire host_go  = host_req && host_ready;
	wire aid_end  = i2c_bus.done && aid_idx_reg == gcc_pkg::AID_LAST;

	assign host_ready   = link_up && seq_idle && eng_free && !power_up;
	assign i2c_bus.req   = req_reg;
	assign i2c_bus.rw    = rw_reg;
	assign i2c_bus.addr  = RX_ADDR;
	assign i2c_bus.wdata = wdata_reg;

	always_ff @(posedge clk) begin
		req_reg       <= 1'b0;
		host_done_reg <= 1'b0;
		if (srst) begin
			aid_state_reg  <= gcc_pkg::GCC_A_IDLE;
			aid_idx_reg    <= 3'h0;
			aid_valid_reg  <= 1'b0;
			rw_reg         <= 1'b0;
			wdata_reg      <= 8'h00;
			host_ack_reg   <= 1'b0;
			host_rdata_reg <= 8'h00;
		end else if (!link_up) begin
			// receiver switched off: abandon any sequence, keep the store
			aid_state_reg <= gcc_pkg::GCC_A_IDLE;
		end else begin
			unique case (aid_state_reg)
				gcc_pkg::GCC_A_IDLE: begin
					aid_idx_reg <= 3'h0;
					if (aid_go && aid_valid_reg) begin
						aid_state_reg <= gcc_pkg::GCC_A_RESTORE;
						req_reg       <= 1'b1;
						rw_reg        <= 1'b0;
						wdata_reg     <= aid_mem_reg[3'h0];
					end else if (aid_go) begin
						aid_state_reg <= gcc_pkg::GCC_A_UPLOAD;
						req_reg       <= 1'b1;
						rw_reg        <= 1'b1;
					end else if (host_go) begin
						aid_state_reg <= gcc_pkg::GCC_A_HOST;
						req_reg       <= 1'b1;
						rw_reg        <= host_rw;
						wdata_reg     <= host_wdata;
					end
				end
				gcc_pkg::GCC_A_RESTORE: begin
					if (i2c_bus.done) begin
						aid_idx_reg <= aid_idx_reg + 3'h1;
						req_reg     <= 1'b1;
						rw_reg      <= aid_end;
						wdata_reg   <= aid_mem_reg[aid_idx_reg + 3'h1];
						if (aid_end)
							aid_state_reg <= gcc_pkg::GCC_A_UPLOAD;
					end
				end
				gcc_pkg::GCC_A_UPLOAD: begin
					if (i2c_bus.done) begin
						aid_idx_reg <= aid_idx_reg + 3'h1;
						if (aid_end) begin
							aid_state_reg <= gcc_pkg::GCC_A_IDLE;
							aid_valid_reg <= 1'b1;
						end else begin
							req_reg <= 1'b1;
						end
					end
				end
				gcc_pkg::GCC_A_HOST: begin
					if (i2c_bus.done) begin
						aid_state_reg  <= gcc_pkg::GCC_A_IDLE;
						host_done_reg  <= 1'b1;
						host_ack_reg   <= i2c_bus.ack_ok;
						host_rdata_reg <= i2c_bus.rdata;
					end
				end
			endcase
		end
	end

	// store written per entry by index
	for (genvar i = 0; i < gcc_pkg::AID_BYTES; i++) begin : g_aid
		always_ff @(posedge clk) begin
			if (srst)
				aid_mem_reg[i] <= 8'h00;
			else if (aid_state_reg == gcc_pkg::GCC_A_UPLOAD &&
				i2c_bus.done && aid_idx_reg == 3'(i))
				aid_mem_reg[i] <= i2c_bus.rdata;
		end
	end

	assign host_done       = host_done_reg;
	assign host_ack_ok     = host_ack_reg;
	assign host_rdata      = host_rdata_reg;
	assign aid_store_valid = aid_valid_reg;

	////////////////////////////////
	// idle gating and wake

	logic idle_reg;
	logic wake_reg;

	// receiver announcing data keeps us awake until it has been read
	wire rx_talking = sense_reg && dr_sync_reg[1];
	wire link_busy  = i2c_bus.busy || req_reg || !seq_idle;
	wire basic_hold = !ext_reg && link_up;

	always_ff @(posedge clk) begin
		if (srst) begin
			idle_reg <= 1'b0;
			wake_reg <= 1'b0;
		end else begin
			idle_reg <= psv_reg && !link_busy && !rx_talking &&
				!basic_hold;
			wake_reg <= sense_reg && dr_sync_reg[1] && !dr_d_reg;
		end
	end

	assign idle_allowed = idle_reg;
	assign wake_pulse   = wake_reg;

endmodule : gcc_top

//--- gcc_pkg.sv
// constants and types shared by the receiver companion control block
//
// Operation
// - receiver i2c traffic only after the host has switched the receiver on
// - the i2c port is a master only and never answers as a slave
// - bus lines are only pulled low or released, never driven high
// - supply-enable pin defaults to pin-function code 3
// - receiver mode 1 drives the supply-enable pin high
// - receiver mode 0, the default, drives the supply-enable pin low
// - data-ready pin defaults to pin-function code 4
// - mode 1 with io setting 16 makes data-ready an input that wakes idle; the code does so only with extended_support set
// - otherwise data-ready is tri-stated with its pull-down on
// - with power saving on and no receiver traffic, idle is allowed
// - rtc-sync pin defaults to pin-function code 5
// - mode 1 with io setting 32 drives the sync signal on rtc-sync; the code does so only with extended_support set
// - otherwise rtc-sync is driven low
// - local aiding saves receiver data and restores it at next power-up
// - basic variant never idles while the receiver link is enabled
package gcc_pkg;

	// clock and bus rate
	localparam int CLK_HZ     = 25_000_000;
	localparam int I2C_BIT_HZ = 100_000;
	localparam int I2C_QTR_CYC_INT =
		(CLK_HZ + 4 * I2C_BIT_HZ - 1) / (4 * I2C_BIT_HZ);
	localparam logic [6:0] I2C_QTR_LAST = 7'(I2C_QTR_CYC_INT - 1);

	// rtc sync timing, in microseconds and in cycles
	localparam int RTC_PERIOD_US  = 1_000_000;
	localparam int RTC_PULSE_US   = 100;
	localparam int RTC_PERIOD_CYC = RTC_PERIOD_US * (CLK_HZ / 1_000_000);
	localparam int RTC_PULSE_CYC  = RTC_PULSE_US * (CLK_HZ / 1_000_000);

	// pin-function codes
	localparam logic [2:0] PINFN_SUPPLY_EN  = 3'h3;
	localparam logic [2:0] PINFN_DATA_READY = 3'h4;
	localparam logic [2:0] PINFN_RTC_SYNC   = 3'h5;

	// receiver io setting bits (16 and 32)
	localparam int IOCFG_DR_BIT  = 4;
	localparam int IOCFG_RTC_BIT = 5;
	localparam logic [7:0] IOCFG_RESET = 8'h00;

	// default receiver address, arbitrary
	localparam logic [6:0] RX_ADDR_DEFAULT = 7'h42;

	// i2c frame: address byte, ack, data byte, ack
	localparam logic [4:0] FRAME_ACK1 = 5'h08;
	localparam logic [4:0] FRAME_LAST = 5'h11;
	localparam logic [4:0] FRAME_D0   = 5'h09;

	// local aiding store
	localparam int AID_BYTES = 8;
	localparam logic [2:0] AID_LAST = 3'h7;

	typedef enum logic [1:0] {
		GCC_E_IDLE  = 2'b00,
		GCC_E_START = 2'b01,
		GCC_E_BITS  = 2'b10,
		GCC_E_STOP  = 2'b11
	} gcc_eng_state_t;

	typedef enum logic [1:0] {
		GCC_A_IDLE    = 2'b00,
		GCC_A_RESTORE = 2'b01,
		GCC_A_UPLOAD  = 2'b10,
		GCC_A_HOST    = 2'b11
	} gcc_aid_state_t;

endpackage : gcc_pkg

//--- gcc_i2c_if.sv
// request and answer signals between the sequencer and the i2c engine
`timescale 1ns/1ns
interface gcc_i2c_if;
	logic       req;
	logic       rw;
	logic [6:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;
	logic       done;
	logic       ack_ok;
	logic       busy;

	modport engine (
		input  req, rw, addr, wdata,
		output rdata, done, ack_ok, busy
	);
	modport client (
		output req, rw, addr, wdata,
		input  rdata, done, ack_ok, busy
	);
endinterface : gcc_i2c_if

//--- gcc_i2c_master.sv
// single-byte i2c master engine, open-drain drive, clock stretching aware
`timescale 1ns/1ns
module gcc_i2c_master (
	// clock and reset
	input  wire logic clk,
	input  wire logic srst,
	// request side
	gcc_i2c_if.engine bus,
	// synchronised bus levels
	input  wire logic scl_in,
	input  wire logic sda_in,
	// pull-low enables
	output logic      scl_oe,
	output logic      sda_oe
);

	gcc_pkg::gcc_eng_state_t state_reg;
	logic [6:0]  qcnt_reg;
	logic [1:0]  ph_reg;
	logic [4:0]  idx_reg;
	logic [17:0] tx_reg;
	logic [7:0]  rx_reg;
	logic        ack_reg;
	logic        rw_reg;
	logic        done_reg;
	logic        scl_low_reg;
	logic        sda_low_reg;

	wire tick      = (qcnt_reg == gcc_pkg::I2C_QTR_LAST);
	wire is_ack    = (idx_reg == gcc_pkg::FRAME_ACK1) ||
		(!rw_reg && idx_reg == gcc_pkg::FRAME_LAST);
	wire is_rdbit  = rw_reg && idx_reg >= gcc_pkg::FRAME_D0 &&
		idx_reg < gcc_pkg::FRAME_LAST;
	// slave holding scl low freezes the sample phase
	wire stretched = (state_reg != gcc_pkg::GCC_E_START) &&
		(ph_reg == 2'h2) && !scl_in;

	// only pull-low enables leave the engine; the pin level is never driven high
	assign scl_oe      = scl_low_reg;
	assign sda_oe      = sda_low_reg;
	assign bus.busy    = (state_reg != gcc_pkg::GCC_E_IDLE);
	assign bus.done    = done_reg;
	assign bus.rdata   = rx_reg;
	assign bus.ack_ok  = ack_reg;

	always_ff @(posedge clk) begin
		if (srst || state_reg == gcc_pkg::GCC_E_IDLE || tick)
			qcnt_reg <= 7'h00;
		else
			qcnt_reg <= qcnt_reg + 7'h01;
	end

	// master-only sequencing; no address match logic exists at all
	always_ff @(posedge clk) begin
		done_reg <= 1'b0;
		if (srst) begin
			state_reg   <= gcc_pkg::GCC_E_IDLE;
			ph_reg      <= 2'h0;
			idx_reg     <= 5'h00;
			tx_reg      <= 18'h3FFFF;
			rx_reg      <= 8'h00;
			ack_reg     <= 1'b0;
			rw_reg      <= 1'b0;
			scl_low_reg <= 1'b0;
			sda_low_reg <= 1'b0;
		end else if (state_reg == gcc_pkg::GCC_E_IDLE) begin
			if (bus.req) begin
				state_reg <= gcc_pkg::GCC_E_START;
				rw_reg    <= bus.rw;
				ack_reg   <= 1'b1;
				ph_reg    <= 2'h0;
				tx_reg    <= {bus.addr, bus.rw, 1'b1,
					bus.rw ? 8'hFF : bus.wdata, 1'b1};
			end
		end else if (tick && !stretched) begin
			ph_reg <= ph_reg + 2'h1;
			unique case (state_reg)
				gcc_pkg::GCC_E_START: begin
					if (ph_reg == 2'h1)
						sda_low_reg <= 1'b1;
					if (ph_reg == 2'h2)
						scl_low_reg <= 1'b1;
					if (ph_reg == 2'h3) begin
						state_reg <= gcc_pkg::GCC_E_BITS;
						idx_reg   <= 5'h00;
					end
				end
				gcc_pkg::GCC_E_BITS: begin
					if (ph_reg == 2'h0)
						sda_low_reg <= ~tx_reg[17];
					if (ph_reg == 2'h1)
						scl_low_reg <= 1'b0;
					if (ph_reg == 2'h2 && is_ack)
						ack_reg <= ack_reg & ~sda_in;
					if (ph_reg == 2'h2 && is_rdbit)
						rx_reg <= {rx_reg[6:0], sda_in};
					if (ph_reg == 2'h3) begin
						scl_low_reg <= 1'b1;
						tx_reg      <= {tx_reg[16:0], 1'b1};
						idx_reg     <= idx_reg + 5'h01;
						if (idx_reg == gcc_pkg::FRAME_LAST)
							state_reg <= gcc_pkg::GCC_E_STOP;
					end
				end
				gcc_pkg::GCC_E_STOP: begin
					if (ph_reg == 2'h0)
						sda_low_reg <= 1'b1;
					if (ph_reg == 2'h1)
						scl_low_reg <= 1'b0;
					if (ph_reg == 2'h2)
						sda_low_reg <= 1'b0;
					if (ph_reg == 2'h3) begin
						state_reg <= gcc_pkg::GCC_E_IDLE;
						done_reg  <= 1'b1;
					end
				end
				default: state_reg <= gcc_pkg::GCC_E_IDLE;
			endcase
		end
	end

endmodule : gcc_i2c_master

//--- gcc_pin_mux.sv
// decides the drive of the three receiver gpio pins from the settings
`timescale 1ns/1ns
module gcc_pin_mux (
	// settings
	input  wire logic       rx_mode,
	input  wire logic       extended,
	input  wire logic [7:0] io_setting,
	input  wire logic [2:0] fn_supply,
	input  wire logic [2:0] fn_ready,
	input  wire logic [2:0] fn_rtc,
	input  wire logic       rtc_level,
	// decided pin drive
	output logic            supply_level,
	output logic            supply_drive,
	output logic            ready_sense,
	output logic            rtc_out_level
);

	wire supply_fn = (fn_supply == gcc_pkg::PINFN_SUPPLY_EN);
	wire ready_fn  = (fn_ready == gcc_pkg::PINFN_DATA_READY);
	wire rtc_fn    = (fn_rtc == gcc_pkg::PINFN_RTC_SYNC);

	// the pin follows the receiver mode; other functions leave it low
	assign supply_level = supply_fn && rx_mode;
	assign supply_drive = 1'b1;

	// sensing only in the full data-ready configuration
	assign ready_sense = ready_fn && extended && rx_mode &&
		io_setting[gcc_pkg::IOCFG_DR_BIT];

	assign rtc_out_level = rtc_fn && extended && rx_mode &&
		io_setting[gcc_pkg::IOCFG_RTC_BIT] && rtc_level;

endmodule : gcc_pin_mux

//--- gcc_top_checker.sv
// port-level checks for the receiver companion control block
`timescale 1ns/1ns
module gcc_top_checker #(
	parameter int RTC_PULSE_CYC = 2500
) (
	input wire logic       clk,
	input wire logic       srst,
	input wire logic       settings_load,
	input wire logic       rx_mode,
	input wire logic [7:0] receiver_io_setting,
	input wire logic [2:0] fn_supply,
	input wire logic [2:0] fn_ready,
	input wire logic [2:0] fn_rtc,
	input wire logic       power_saving_en,
	input wire logic       extended_support,
	input wire logic       host_ready,
	input wire logic       idle_allowed,
	input wire logic       wake_pulse,
	input wire logic       scl_o,
	input wire logic       scl_oe,
	input wire logic       sda_o,
	input wire logic       sda_oe,
	input wire logic       gps_supply_enable_pin_o,
	input wire logic       gps_supply_enable_pin_oe,
	input wire logic       gps_data_ready_pin_i,
	input wire logic       gps_data_ready_pin_pd_en,
	input wire logic       gps_rtc_sync_pin_o,
	input wire logic       gps_rtc_sync_pin_oe
);
	logic       on_q, dr_q, rt_q, psv_q, ext_q;
	logic [2:0] fs_q, fr_q, ft_q;
	logic [1:0] age;
	int         hi_cnt;
	wire sup_h = on_q && fs_q == gcc_pkg::PINFN_SUPPLY_EN;
	wire sns_h = on_q && ext_q && dr_q && fr_q == gcc_pkg::PINFN_DATA_READY;
	wire rtc_h = on_q && ext_q && rt_q && ft_q == gcc_pkg::PINFN_RTC_SYNC;

	// shadow of the settings; age holds off checks while pins catch up
	always_ff @(posedge clk) begin
		if (srst) begin
			{on_q, dr_q, rt_q, psv_q, ext_q} <= 5'h00;
			{fs_q, fr_q, ft_q} <= {3'h3, 3'h4, 3'h5};
			age <= 2'h0;
		end else if (settings_load) begin
			{on_q, psv_q, ext_q} <= {rx_mode, power_saving_en, extended_support};
			{dr_q, rt_q} <= {receiver_io_setting[4], receiver_io_setting[5]};
			{fs_q, fr_q, ft_q} <= {fn_supply, fn_ready, fn_rtc};
			age <= 2'h0;
		end else if (age != 2'h3) begin
			age <= age + 2'h1;
		end
	end
	always_ff @(posedge clk) begin
		hi_cnt <= (srst || !gps_rtc_sync_pin_o) ? 0 : hi_cnt + 1;
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	AST_LINK_OFF: assert property (!on_q |-> !host_ready)
		else $error("host relay open while receiver off");
	AST_LINK_QUIET: assert property (!on_q && age == 2'h3 |-> !scl_oe && !sda_oe)
		else $error("bus pulled while receiver off");
	AST_OPEN_DRAIN: assert property (scl_o == 1'b0 && sda_o == 1'b0)
		else $error("bus line driven high");
	AST_SUPPLY: assert property (age != 2'h0 |->
		gps_supply_enable_pin_oe && gps_supply_enable_pin_o == sup_h)
		else $error("supply pin wrong");
	AST_SUPPLY_RESET: assert property ($fell(srst) |->
		!(gps_supply_enable_pin_o && gps_supply_enable_pin_oe))
		else $error("supply pin high in reset");
	AST_READY_PD: assert property (age != 2'h0 |-> gps_data_ready_pin_pd_en == !sns_h)
		else $error("data-ready pull-down wrong");
	AST_WAKE: assert property (sns_h && $rose(gps_data_ready_pin_i) |-> ##[1:5] wake_pulse)
		else $error("no wake on data-ready");
	AST_WAKE_ONLY: assert property (wake_pulse |-> sns_h ##1 !wake_pulse)
		else $error("stray or long wake pulse");
	AST_RTC_LOW: assert property (age != 2'h0 && !rtc_h |->
		gps_rtc_sync_pin_oe && !gps_rtc_sync_pin_o)
		else $error("sync pin not low");
	AST_RTC_WIDTH: assert property (rtc_h && $past(rtc_h) && $fell(gps_rtc_sync_pin_o) |->
		hi_cnt == RTC_PULSE_CYC)
		else $error("sync pulse width wrong");
	AST_IDLE_BLOCK: assert property (idle_allowed && age != 2'h0 |-> psv_q && (ext_q || !on_q))
		else $error("idle allowed wrongly");
	AST_IDLE_FREE: assert property (age == 2'h3 && psv_q && !on_q && !scl_oe |-> idle_allowed)
		else $error("idle withheld");
endmodule : gcc_top_checker

//--- gcc_rx_model.sv
// behavioural receiver on the two-wire bus and the data-ready line
`timescale 1ns/1ns
module gcc_rx_model #(
	parameter logic [6:0] ADDR = 7'h42
) (
	input wire logic  clk,
	input wire logic  scl,
	input wire logic  sda,
	input wire logic  has_data,
	input wire logic  stretch,
	output logic      sda_pull,
	output logic      scl_pull,
	output logic      ready_pin,
	output logic [7:0] last_w,
	output logic [7:0] n_rd
);
	logic       scl_q = 1'b1, sda_q = 1'b1, rd = 1'b0, hit = 1'b0;
	logic [4:0] idx = 5'h00;
	logic [7:0] sh = 8'h00;
	logic [7:0] hold = 8'h00;
	wire [7:0]  rbyte = {4'hA, n_rd[3:0]};
	initial {sda_pull, last_w, n_rd} = 17'h0;
	assign scl_pull  = hold != 8'h00;
	assign ready_pin = has_data;

	always @(posedge clk) begin
		scl_q <= scl;
		sda_q <= sda;
		if (hold != 8'h00)
			hold <= hold - 8'h01;
		if (scl && !scl_q)
			sh <= {sh[6:0], sda};
		if (scl && scl_q && sda_q && !sda) begin
			idx      <= 5'h1F; // start fall wraps to 0
			sda_pull <= 1'b0;
		end
		// decide the next bit just after clock falls; release is the default
		if (!scl && scl_q) begin
			idx      <= idx + 5'h01;
			hold     <= stretch ? 8'hFF : 8'h00;
			sda_pull <= 1'b0;
			if (idx == 5'h07) begin
				hit      <= sh[7:1] == ADDR;
				rd       <= sh[0];
				sda_pull <= sh[7:1] == ADDR;
			end else if (rd && hit && idx >= 5'h08 && idx < 5'h10) begin
				sda_pull <= !rbyte[3'(5'h0F - idx)];
			end else if (idx == 5'h10 && hit) begin
				if (rd) begin
					n_rd <= n_rd + 8'h01;
				end else begin
					last_w   <= sh;
					sda_pull <= 1'b1;
				end
			end
		end
	end
endmodule : gcc_rx_model

//--- test_gcc_top.sv
// self-checking testbench for the receiver companion control block
`timescale 1ns/1ns
module test_gcc_top;
	logic       clk = 1'b0, srst = 1'b1, settings_load = 1'b0, rx_mode = 1'b0;
	logic       power_saving_en = 1'b0, local_aiding_en = 1'b0;
	logic       extended_support = 1'b1, host_req = 1'b0, host_rw = 1'b0;
	logic [7:0] receiver_io_setting = 8'h00, host_wdata = 8'h00;
	logic [2:0] fn_supply = 3'h3, fn_ready = 3'h4, fn_rtc = 3'h5;
	logic       has_data = 1'b0, stretch = 1'b0;
	logic       host_ready, host_done, host_ack_ok, idle_allowed, wake_pulse;
	logic       aid_store_valid, scl_o, scl_oe, sda_o, sda_oe, m_sda, m_scl;
	logic       gps_supply_enable_pin_o, gps_supply_enable_pin_oe;
	logic       gps_data_ready_pin_i, gps_data_ready_pin_pd_en;
	logic       gps_rtc_sync_pin_o, gps_rtc_sync_pin_oe;
	logic [7:0] host_rdata, last_w, n_rd, ex;
	int         error_cnt = 0, tests_run = 0, cyc = 0;
	// released lines float up through the pull-ups
	wire        scl_i = ~(scl_oe | m_scl);
	wire        sda_i = ~(sda_oe | m_sda);
	wire [7:0]  sup = {6'h00, gps_supply_enable_pin_oe,
		gps_supply_enable_pin_o};

	gcc_top #(.RTC_PERIOD_CYC(200), .RTC_PULSE_CYC(20)) i_dut (.clk, .srst,
		.settings_load, .rx_mode, .receiver_io_setting, .fn_supply, .fn_ready,
		.fn_rtc, .power_saving_en, .local_aiding_en, .extended_support,
		.host_req, .host_rw, .host_wdata, .host_ready, .host_done, .host_ack_ok,
		.host_rdata, .idle_allowed, .wake_pulse, .aid_store_valid, .scl_i,
		.scl_o, .scl_oe, .sda_i, .sda_o, .sda_oe, .gps_supply_enable_pin_o,
		.gps_supply_enable_pin_oe, .gps_data_ready_pin_i,
		.gps_data_ready_pin_pd_en, .gps_rtc_sync_pin_o, .gps_rtc_sync_pin_oe);
	gcc_rx_model #(.ADDR(gcc_pkg::RX_ADDR_DEFAULT)) i_rx (.clk, .scl(scl_i),
		.sda(sda_i), .has_data, .stretch, .sda_pull(m_sda), .scl_pull(m_scl),
		.ready_pin(gps_data_ready_pin_i), .last_w, .n_rd);

	always #20 clk = ~clk;
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 90000) begin
			error_cnt++;
			complete_run();
		end
	end
	////////////////////////////////
	task automatic complete_run();
		$display("tests_run %0d error_cnt %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : complete_run
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick
	task automatic load(input logic m, input logic [7:0] io,
		input logic [2:0] fs, fr, ft, input logic ps, ad, ex_s);
		{settings_load, rx_mode, receiver_io_setting} = {1'b1, m, io};
		{fn_supply, fn_ready, fn_rtc} = {fs, fr, ft};
		{power_saving_en, local_aiding_en, extended_support} = {ps, ad, ex_s};
		tick(1);
		settings_load = 1'b0;
		tick(2);
	endtask : load
	task automatic xfer(input logic rw, input logic [7:0] wd);
		int n = 0;
		while (host_ready !== 1'b1 && n < 20000) begin tick(1); n++; end
		{host_rw, host_wdata, host_req} = {rw, wd, 1'b1};
		tick(1);
		host_req = 1'b0;
		n = 0;
		while (host_done !== 1'b1 && n < 20000) begin tick(1); n++; end
		chk({7'h00, host_done}, 8'h01);
	endtask : xfer
	////////////////////////////////
	task automatic t_power_on();
		load(1'b1, 8'h30, 3'h3, 3'h4, 3'h5, 1'b1, 1'b0, 1'b1);
		chk(sup, 8'h03);
		chk({7'h00, gps_data_ready_pin_pd_en}, 8'h00);
		chk({6'h00, host_ready, idle_allowed}, 8'h03);
		$display("test power_on done");
	endtask : t_power_on
	task automatic t_bytes();
		xfer(1'b0, 8'hA5);
		chk({host_ack_ok, last_w[6:0]}, {1'b1, 7'h25});
		stretch = 1'b1;
		xfer(1'b0, 8'h3C);
		chk(last_w, 8'h3C);
		stretch = 1'b0;
		ex = {4'hA, n_rd[3:0]};
		xfer(1'b1, 8'h00);
		chk(host_rdata, ex);
		$display("test bytes done");
	endtask : t_bytes
	task automatic t_wake();
		int n = 0;
		has_data = 1'b1;
		while (wake_pulse !== 1'b1 && n < 8) begin tick(1); n++; end
		chk({7'h00, wake_pulse}, 8'h01);
		tick(3);
		chk({7'h00, idle_allowed}, 8'h00);
		has_data = 1'b0;
		$display("test wake done");
	endtask : t_wake
	task automatic t_rtc();
		int n = 0, w = 0;
		while (gps_rtc_sync_pin_o === 1'b1 && n < 400) begin tick(1); n++; end
		while (gps_rtc_sync_pin_o !== 1'b1 && n < 400) begin tick(1); n++; end
		while (gps_rtc_sync_pin_o === 1'b1 && w < 100) begin tick(1); w++; end
		chk(8'(w), 8'h14);
		chk({7'h00, gps_rtc_sync_pin_oe}, 8'h01);
		$display("test rtc done");
	endtask : t_rtc
	task automatic t_codes();
		load(1'b1, 8'h30, 3'h0, 3'h0, 3'h0, 1'b1, 1'b0, 1'b1);
		chk(sup, 8'h02);
		chk({7'h00, gps_data_ready_pin_pd_en}, 8'h01);
		chk({6'h00, gps_rtc_sync_pin_oe, gps_rtc_sync_pin_o}, 8'h02);
		$display("test codes done");
	endtask : t_codes
	task automatic t_basic();
		load(1'b1, 8'h00, 3'h3, 3'h4, 3'h5, 1'b1, 1'b0, 1'b0);
		chk({7'h00, idle_allowed}, 8'h00);
		load(1'b0, 8'h00, 3'h3, 3'h4, 3'h5, 1'b1, 1'b0, 1'b0);
		tick(2);
		chk({6'h00, gps_supply_enable_pin_o, idle_allowed}, 8'h01);
		$display("test basic done");
	endtask : t_basic
	task automatic t_aid();
		int n = 0;
		ex = n_rd + 8'h08;
		load(1'b1, 8'h00, 3'h3, 3'h4, 3'h5, 1'b0, 1'b1, 1'b1);
		tick(1);
		chk({7'h00, host_ready}, 8'h00);
		while (aid_store_valid !== 1'b1 && n < 60000) begin tick(1); n++; end
		chk({7'h00, aid_store_valid}, 8'h01);
		chk(n_rd, ex);
		$display("test aid done");
	endtask : t_aid
	////////////////////////////////
	initial begin
		tick(3);
		chk(sup, 8'h00);
		srst = 1'b0;
		tick(2);
		chk(sup, 8'h02);
		chk({6'h00, gps_rtc_sync_pin_oe, gps_data_ready_pin_pd_en}, 8'h03);
		chk({6'h00, host_ready, scl_oe}, 8'h00);
		t_power_on();
		t_bytes();
		t_wake();
		t_rtc();
		t_codes();
		t_basic();
		t_aid();
		complete_run();
	end
endmodule : test_gcc_top

bind gcc_top gcc_top_checker #(.RTC_PULSE_CYC(RTC_PULSE_CYC)) i_chk (.clk,
	.srst, .settings_load, .rx_mode, .receiver_io_setting, .fn_supply,
	.fn_ready, .fn_rtc, .power_saving_en, .extended_support, .host_ready,
	.idle_allowed, .wake_pulse, .scl_o, .scl_oe, .sda_o, .sda_oe,
	.gps_supply_enable_pin_o, .gps_supply_enable_pin_oe, .gps_data_ready_pin_i,
	.gps_data_ready_pin_pd_en, .gps_rtc_sync_pin_o, .gps_rtc_sync_pin_oe);
